// ==== hrs_consts.svh ====
// constants of the host reset and strap sequencer
`ifndef HRS_CONSTS_SVH
`define HRS_CONSTS_SVH

`define HRS_CLK_KHZ          10000
`define HRS_HRST_US          100
`define HRS_PLL_SETUP_US     100
`define HRS_POR_SETUP_CYC    4
`define HRS_HOLD_MIN_CYC     2
`define HRS_REL_MAX_CYC      5
`define HRS_PLL_LOCK_US      100
`define HRS_LBC_LOCK_US      50
`define HRS_CORE_EXTRA_PLAT  255
`define HRS_SRST_MIN_CYC     3

`define HRS_PLAT_BASE_MHZ    400
`define HRS_PCIE_X8_MIN_MHZ  527
`define HRS_SRIO_NUM         16
`define HRS_SRIO_DEN         640

// cycle counts derived from the times, least times rounded up
`define HRS_US_CYC(us)       (((us) * `HRS_CLK_KHZ + 999) / 1000)
`define HRS_HRST_CYC         `HRS_US_CYC(`HRS_HRST_US)
`define HRS_PLL_SETUP_CYC    `HRS_US_CYC(`HRS_PLL_SETUP_US)
`define HRS_SETUP_CYC        ((`HRS_HRST_CYC > `HRS_PLL_SETUP_CYC) ? `HRS_HRST_CYC : \
                              `HRS_PLL_SETUP_CYC)
`define HRS_REL_CYC          3
`define HRS_CORE_EXTRA_CYC   ((`HRS_CORE_EXTRA_PLAT * `HRS_CLK_KHZ + \
                              `HRS_PLAT_BASE_MHZ * 1000 - 1) / (`HRS_PLAT_BASE_MHZ * 1000))
`define HRS_LOCK_CYC         (`HRS_US_CYC(`HRS_PLL_LOCK_US) + `HRS_CORE_EXTRA_CYC)
`define HRS_CNT_W            11

`endif

// ==== hrs_dev_model.sv ====
// device side model: strap capture at reset release and pll lock
`timescale 1ns/1ps
module hrs_dev_model #(
  parameter int PLL_W    = 4,
  parameter int POR_W    = 16,
  parameter int LOCK_CYC = 32'h0000_03ef
) (
  input  wire logic                   i_clk,
  input  wire hrs_pkg::hrs_rst_pins_t i_rst,
  input  wire logic [PLL_W-1:0]       i_pll,
  input  wire logic [POR_W-1:0]       i_por,
  input  wire logic                   i_oe_b,
  output logic [PLL_W-1:0]            o_pll_seen,
  output logic [POR_W-1:0]            o_por_seen,
  output logic                        o_locked
);
  logic hr_q = 1'b0;
  int   lk   = 0;
  // a released pin reads inverted so that an early release cannot look valid
  always @(posedge i_clk) begin
    hr_q <= i_rst.hard_rst_b;
    if (i_rst.hard_rst_b && !hr_q) begin
      o_pll_seen <= i_oe_b ? ~i_pll : i_pll;
      o_por_seen <= i_oe_b ? ~i_por : i_por;
    end
    lk <= i_rst.hard_rst_b ? lk + 1 : 0;
    // lock at the slowest legal time plus the core tail
    o_locked <= i_rst.hard_rst_b && lk >= LOCK_CYC;
  end
endmodule : hrs_dev_model

// ==== hrs_pkg.sv ====
// types of the host reset and strap sequencer
package hrs_pkg;

  typedef enum logic [2:0] {
    HRS_IDLE,
    HRS_SETUP,
    HRS_HOLD,
    HRS_LOCK,
    HRS_READY
  } hrs_state_t;

  // reset pins towards the device, all active low
  typedef struct packed {
    logic       hard_rst_b;
    logic [1:0] soft_rst_b;
  } hrs_rst_pins_t;

  // board clocking plan the straps must suit
  typedef struct packed {
    logic [11:0] plat_mhz;
    logic        pcie_x8;
    logic [11:0] srio_mhz;
    logic [3:0]  srio_width;
  } hrs_plat_cfg_t;

endpackage : hrs_pkg

// ==== hrs_seq_chk_sva.sv ====
// assertions on the reset sequencer ports
`timescale 1ns/1ps
module hrs_seq_chk #(
  parameter int PLL_W = 4,
  parameter int POR_W = 16
) (
  input wire logic                   I_CLK,
  input wire logic                   I_RST_B,
  input wire hrs_pkg::hrs_plat_cfg_t I_PLAT_CFG,
  input wire hrs_pkg::hrs_rst_pins_t O_RST,
  input wire logic [PLL_W-1:0]       O_PLL_CFG,
  input wire logic                   O_PLL_OE_B,
  input wire logic [POR_W-1:0]       O_POR_CFG,
  input wire logic                   O_PLAT_FREQ_SEL,
  input wire logic                   O_POR_OE_B,
  input wire logic                   O_READY,
  input wire logic                   O_CFG_ERR
);
  // saturating counts: straps driven under reset, and time since release
  logic [10:0] su_r, su_nxt, lk_r, lk_nxt;
  always_comb begin
    su_nxt = (O_PLL_OE_B || O_RST.hard_rst_b) ? '0 : su_r + 11'(su_r != 11'h7ff);
    lk_nxt = !O_RST.hard_rst_b ? '0 : lk_r + 11'(lk_r != 11'h7ff);
  end
  always_ff @(posedge I_CLK) begin
    su_r <= I_RST_B ? su_nxt : '0;
    lk_r <= I_RST_B ? lk_nxt : '0;
  end
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);
  hrst_setup_a: assert property (
    $rose(O_RST.hard_rst_b) |-> su_r >= 11'h3e8) else $error("reset released early");
  strap_hold_a: assert property (
    $rose(O_RST.hard_rst_b) |-> (!O_POR_OE_B && $stable(O_POR_CFG) && $stable(O_PLL_CFG))[*3])
    else $error("straps not held");
  strap_release_a: assert property (
    $rose(O_RST.hard_rst_b) |-> ##[1:5] (O_POR_OE_B && O_PLL_OE_B)) else $error("straps kept");
  soft0_width_a: assert property (
    $fell(O_RST.soft_rst_b[0]) |-> (!O_RST.soft_rst_b[0])[*3] ##1 O_RST.soft_rst_b[0])
    else $error("core0 pulse width");
  soft1_width_a: assert property (
    $fell(O_RST.soft_rst_b[1]) |-> (!O_RST.soft_rst_b[1])[*3] ##1 O_RST.soft_rst_b[1])
    else $error("core1 pulse width");
  ready_lock_a: assert property (
    $rose(O_READY) |-> lk_r >= 11'h3ef) else $error("ready before lock");
  soft_ready_a: assert property (
    (O_RST.soft_rst_b != 2'b11) |-> O_READY) else $error("soft reset before ready");
  freq_sel_a: assert property (
    !O_POR_OE_B |-> O_PLAT_FREQ_SEL == (I_PLAT_CFG.plat_mhz > 12'h190)) else $error("freq sel");
  pcie_plan_a: assert property (
    !O_PLL_OE_B && I_PLAT_CFG.pcie_x8 |->
    I_PLAT_CFG.plat_mhz == 12'h190 || I_PLAT_CFG.plat_mhz >= 12'h20f) else $error("x8 plan");
  srio_plan_a: assert property (
    !O_PLL_OE_B && I_PLAT_CFG.srio_width != 4'h0 |-> 32'(I_PLAT_CFG.plat_mhz) * 32'h0000_0280 >
    32'(I_PLAT_CFG.srio_mhz) * 32'(I_PLAT_CFG.srio_width) * 32'h0000_0010)
    else $error("srio plan");
  refuse_still_a: assert property (
    $rose(O_CFG_ERR) |-> !O_RST.hard_rst_b && O_PLL_OE_B) else $error("refused plan moved");
  cover property ($rose(O_READY));
  cover property ($rose(O_CFG_ERR));
  cover property ($fell(O_RST.soft_rst_b[1]));
endmodule : hrs_seq_chk
bind hrs_sequencer hrs_seq_chk #(.PLL_W(PLL_W), .POR_W(POR_W)) i_hrs_seq_chk (
  .I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_PLAT_CFG(I_PLAT_CFG), .O_RST(O_RST),
  .O_PLL_CFG(O_PLL_CFG), .O_PLL_OE_B(O_PLL_OE_B), .O_POR_CFG(O_POR_CFG),
  .O_PLAT_FREQ_SEL(O_PLAT_FREQ_SEL), .O_POR_OE_B(O_POR_OE_B), .O_READY(O_READY),
  .O_CFG_ERR(O_CFG_ERR));

// ==== hrs_sequencer.sv ====
// host side power-on reset, strap and soft reset sequencer
`timescale 1ns/1ps
`include "hrs_consts.svh"

module hrs_sequencer #(
  parameter int PLL_W = 4,
  parameter int POR_W = 16
) (
  input  wire logic                  I_CLK,
  input  wire logic                  I_RST_B,
  input  wire logic                  I_START,
  input  wire hrs_pkg::hrs_plat_cfg_t I_PLAT_CFG,
  input  wire logic [PLL_W-1:0]      I_PLL_CFG,
  input  wire logic [POR_W-1:0]      I_POR_CFG,
  input  wire logic [1:0]            I_SRST_REQ,
  output hrs_pkg::hrs_rst_pins_t     O_RST,
  output logic [PLL_W-1:0]           O_PLL_CFG,
  output logic                       O_PLL_OE_B,
  output logic [POR_W-1:0]           O_POR_CFG,
  output logic                       O_PLAT_FREQ_SEL,
  output logic                       O_POR_OE_B,
  output logic                       O_READY,
  output logic                       O_CFG_ERR,
  output logic [1:0]                 O_SRST_BUSY
);

  if (PLL_W < 1 || PLL_W > 8 || POR_W < 1 || POR_W > 64) begin : g_bad_width
    $error("hrs_sequencer: strap width out of range");
  end

  // every interval must fit the shared counter, or the sequence would wrap early
  if (`HRS_SETUP_CYC > (1 << `HRS_CNT_W) || `HRS_LOCK_CYC > (1 << `HRS_CNT_W)) begin : g_bad_cnt
    $error("hrs_sequencer: interval counter too narrow");
  end

  // the fixed release point must lie past the least hold and inside the latest release
  if (`HRS_REL_CYC < `HRS_HOLD_MIN_CYC || `HRS_REL_CYC > `HRS_REL_MAX_CYC) begin : g_bad_rel
    $error("hrs_sequencer: strap release outside its window");
  end

  // the long setup wait also covers the short setup of the other straps
  if (`HRS_SETUP_CYC < `HRS_POR_SETUP_CYC) begin : g_bad_setup
    $error("hrs_sequencer: strap setup shorter than required");
  end

  // one lock wait serves all plls only while the local bus pll is the quicker one
  if (`HRS_LBC_LOCK_US > `HRS_PLL_LOCK_US) begin : g_bad_lock
    $error("hrs_sequencer: local bus pll lock exceeds the lock wait");
  end

  //////////////////////////////////////////////////////////////////////////////
  // clocking plan check

  logic        freq_sel;
  logic        base_ok;
  logic        pcie_ok;
  logic        srio_ok;
  logic        cfg_ok;
  logic [23:0] srio_lhs;
  logic [23:0] srio_rhs;

  // select is low at the base rate and high above it; below the base rate is refused
  always_comb begin
    freq_sel = I_PLAT_CFG.plat_mhz > 12'(`HRS_PLAT_BASE_MHZ);
    base_ok  = I_PLAT_CFG.plat_mhz >= 12'(`HRS_PLAT_BASE_MHZ);
  end

  // an eight lane link needs the base rate exactly, or the fast band
  always_comb begin
    pcie_ok = 1'b1;
    if (I_PLAT_CFG.pcie_x8 &&
        I_PLAT_CFG.plat_mhz != 12'(`HRS_PLAT_BASE_MHZ) &&
        I_PLAT_CFG.plat_mhz <  12'(`HRS_PCIE_X8_MIN_MHZ)) begin
      pcie_ok = 1'b0;
    end
  end

  // plat > 16 x f x w / 640, rearranged to stay in integers; 24 bits hold the largest plat
  always_comb begin
    srio_lhs = 24'(I_PLAT_CFG.plat_mhz) * 24'(`HRS_SRIO_DEN);
    srio_rhs = 24'(I_PLAT_CFG.srio_mhz) * 24'(I_PLAT_CFG.srio_width) * 24'(`HRS_SRIO_NUM);
    srio_ok  = (I_PLAT_CFG.srio_width == 4'h0) || (srio_lhs > srio_rhs);
  end

  assign cfg_ok = base_ok && pcie_ok && srio_ok;

  //////////////////////////////////////////////////////////////////////////////
  // power-on sequence

  localparam logic [`HRS_CNT_W-1:0] SETUP_LAST = `HRS_CNT_W'(`HRS_SETUP_CYC - 1);
  localparam logic [`HRS_CNT_W-1:0] REL_LAST   = `HRS_CNT_W'(`HRS_REL_CYC - 1);
  localparam logic [`HRS_CNT_W-1:0] LOCK_LAST  = `HRS_CNT_W'(`HRS_LOCK_CYC - 1);

  hrs_pkg::hrs_state_t   state_r;
  hrs_pkg::hrs_state_t   state_nxt;
  logic [`HRS_CNT_W-1:0] cnt_r;
  logic [`HRS_CNT_W-1:0] cnt_nxt;
  logic                  hard_rst_b_r;
  logic                  hard_rst_b_nxt;
  logic                  oe_b_r;
  logic                  oe_b_nxt;
  logic [PLL_W-1:0]      pll_r;
  logic [PLL_W-1:0]      pll_nxt;
  logic [POR_W-1:0]      por_r;
  logic [POR_W-1:0]      por_nxt;
  logic                  fsel_r;
  logic                  fsel_nxt;
  logic                  err_r;
  logic                  err_nxt;

  // every interval is counted on I_CLK, which also feeds the device
  always_comb begin
    state_nxt      = state_r;
    cnt_nxt        = cnt_r + `HRS_CNT_W'(1);
    hard_rst_b_nxt = hard_rst_b_r;
    oe_b_nxt       = oe_b_r;
    pll_nxt        = pll_r;
    por_nxt        = por_r;
    fsel_nxt       = fsel_r;
    err_nxt        = err_r;
    unique case (state_r)
      hrs_pkg::HRS_IDLE: begin
        cnt_nxt = '0;
        if (I_START) begin
          err_nxt = !cfg_ok;
          if (cfg_ok) begin
            // straps are captured once so they cannot move while presented
            pll_nxt   = I_PLL_CFG;
            por_nxt   = I_POR_CFG;
            fsel_nxt  = freq_sel;
            oe_b_nxt  = 1'b0;
            state_nxt = hrs_pkg::HRS_SETUP;
          end
        end
      end
      hrs_pkg::HRS_SETUP: begin
        // hard reset has been low since our own reset; setup covers pll and other straps
        if (cnt_r == SETUP_LAST) begin
          hard_rst_b_nxt = 1'b1;
          cnt_nxt        = '0;
          state_nxt      = hrs_pkg::HRS_HOLD;
        end
      end
      hrs_pkg::HRS_HOLD: begin
        // release after 3 cycles: past the least hold, inside the latest release
        if (cnt_r == REL_LAST) begin
          oe_b_nxt  = 1'b1;
          cnt_nxt   = '0;
          state_nxt = hrs_pkg::HRS_LOCK;
        end
      end
      hrs_pkg::HRS_LOCK: begin
        // worst pll lock plus the core pll tail at the slowest legal platform clock
        if (cnt_r == LOCK_LAST) begin
          cnt_nxt   = '0;
          state_nxt = hrs_pkg::HRS_READY;
        end
      end
      hrs_pkg::HRS_READY: begin
        cnt_nxt = '0;
      end
      default: begin
        state_nxt = hrs_pkg::HRS_IDLE;
        cnt_nxt   = '0;
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      state_r      <= hrs_pkg::HRS_IDLE;
      cnt_r        <= '0;
      hard_rst_b_r <= 1'b0;
      oe_b_r       <= 1'b1;
      pll_r        <= '0;
      por_r        <= '0;
      fsel_r       <= 1'b0;
      err_r        <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      cnt_r        <= cnt_nxt;
      hard_rst_b_r <= hard_rst_b_nxt;
      oe_b_r       <= oe_b_nxt;
      pll_r        <= pll_nxt;
      por_r        <= por_nxt;
      fsel_r       <= fsel_nxt;
      err_r        <= err_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // core soft resets, only once the cores are usable

  logic       ready;
  logic [1:0] soft_rst_b;

  assign ready = state_r == hrs_pkg::HRS_READY;

  for (genvar g = 0; g < 2; g++) begin : g_core
    hrs_srst_pulse #(
      .PULSE_CYC (`HRS_SRST_MIN_CYC)
    ) u_pulse (
      .i_clk    (I_CLK),
      .i_rst_b  (I_RST_B),
      .i_enable (ready),
      .i_req    (I_SRST_REQ[g]),
      .o_srst_b (soft_rst_b[g]),
      .o_busy   (O_SRST_BUSY[g])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign O_RST.hard_rst_b = hard_rst_b_r;
  assign O_RST.soft_rst_b = soft_rst_b;
  assign O_PLL_CFG        = pll_r;
  assign O_PLL_OE_B       = oe_b_r;
  assign O_POR_CFG        = por_r;
  assign O_PLAT_FREQ_SEL  = fsel_r;
  assign O_POR_OE_B       = oe_b_r;
  assign O_READY          = ready;
  assign O_CFG_ERR        = err_r;

endmodule : hrs_sequencer

// ==== hrs_sequencer_tb_top.sv ====
// self-checking bench of the reset sequencer
`timescale 1ns/1ps
module hrs_sequencer_tb_top;
  logic I_CLK = 1'b0, I_RST_B = 1'b0, I_START = 1'b0;
  hrs_pkg::hrs_plat_cfg_t cfg = '0;
  hrs_pkg::hrs_rst_pins_t rst;
  logic [3:0] pll = '0, pll_o, pll_s;
  logic [15:0] por = '0, por_o, por_s;
  logic [1:0] req = '0, busy;
  logic pll_oe_b, sel, por_oe_b, rdy, err, lkd;
  int miscompares = 0, total_checks = 0, seed = 23434, n, ok;
  time t0, t1, t2, t3;
  always #50 I_CLK = ~I_CLK;
  always @(negedge pll_oe_b) t0 = $time;
  always @(posedge rst.hard_rst_b) t1 = $time;
  always @(posedge pll_oe_b) t2 = $time;
  always @(posedge rdy) t3 = $time;
  hrs_sequencer i_hrs_sequencer (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_START(I_START),
    .I_PLAT_CFG(cfg), .I_PLL_CFG(pll), .I_POR_CFG(por), .I_SRST_REQ(req), .O_RST(rst),
    .O_PLL_CFG(pll_o), .O_PLL_OE_B(pll_oe_b), .O_POR_CFG(por_o), .O_PLAT_FREQ_SEL(sel),
    .O_POR_OE_B(por_oe_b), .O_READY(rdy), .O_CFG_ERR(err), .O_SRST_BUSY(busy));
  hrs_dev_model i_hrs_dev_model (.i_clk(I_CLK), .i_rst(rst), .i_pll(pll_o), .i_por(por_o),
    .i_oe_b(por_oe_b), .o_pll_seen(pll_s), .o_por_seen(por_s), .o_locked(lkd));
  task automatic tick;
    @(posedge I_CLK);
    #1;
  endtask : tick
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report
  function automatic int plan_ok(int p, int x, int s, int w);
    return p >= 400 && (!x || p == 400 || p >= 527) && (w == 0 || p * 640 > s * w * 16);
  endfunction : plan_ok
  task automatic do_reset;
    I_RST_B = 1'b0;
    I_START = 1'b0;
    req = 2'b00;
    repeat (8) tick;
    check("reset pins", rst, 32'h0000_0003);
    check("reset flags", {pll_oe_b, por_oe_b, rdy, err, busy}, 32'h0000_0030);
    I_RST_B = 1'b1;
  endtask : do_reset
  // random plans until one is accepted; refused ones leave the sequencer idle
  task automatic pick_plan;
    ok = 0;
    while (!ok) begin
      cfg = 29'($random(seed));
      cfg.plat_mhz = 12'h17c + 12'($unsigned($random(seed)) % 200);
      cfg.srio_mhz = 12'($unsigned($random(seed)) % 2000);
      {pll, por} = 20'($random(seed));
      ok = plan_ok(cfg.plat_mhz, cfg.pcie_x8, cfg.srio_mhz, cfg.srio_width);
      I_START = 1'b1;
      tick;
      I_START = 1'b0;
      tick;
      check("cfg_err", err, !ok);
    end
  endtask : pick_plan
  task automatic run_seq;
    pick_plan;
    check("straps", {sel, pll_o, por_o}, {cfg.plat_mhz > 12'h190, pll, por});
    req = 2'b11;
    n = 0;
    while (rdy !== 1'b1 && n < 3000) begin
      tick;
      n++;
    end
    check("ready wait", rdy, 1'b1);
    check("setup", 32'((t1 - t0) / 100), 32'h0000_03e8);
    check("release", 32'((t2 - t1) / 100), 32'h0000_0003);
    check("ready", 32'((t3 - t2) / 100), 32'h0000_03ef);
    check("seen", {lkd, pll_s, por_s}, {1'b1, pll, por});
    check("soft early", rst.soft_rst_b, 2'b11);
    for (int k = 1; k < 6; k++) begin
      tick;
      check("soft pulse", {busy, rst.soft_rst_b}, k == 4 ? 4'b0011 : 4'b1100);
    end
    req = 2'b00;
    repeat (4) tick;
    $display("sequence test done");
  endtask : run_seq
  // a start in ready, even with a refused plan, must leave hard reset, strap enable, ready and error as they are
  task automatic start_ignored;
    cfg.plat_mhz = 12'h17c;
    I_START = 1'b1;
    tick;
    I_START = 1'b0;
    repeat (2) tick;
    check("ignored start", {rst.hard_rst_b, por_oe_b, rdy, err}, 32'h0000_000e);
    $display("ignored start test done");
  endtask : start_ignored
  initial begin
    do_reset;
    run_seq;
    start_ignored;
    repeat (500) tick;
    do_reset;
    run_seq;
    final_report;
  end
  initial begin
    #(12000 * 100);
    miscompares++;
    final_report;
  end
endmodule : hrs_sequencer_tb_top

// ==== hrs_srst_pulse.sv ====
// one core soft reset pulse stretcher
`timescale 1ns/1ps
`include "hrs_consts.svh"

module hrs_srst_pulse #(
  parameter int PULSE_CYC = `HRS_SRST_MIN_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_enable,
  input  wire logic i_req,
  output logic      o_srst_b,
  output logic      o_busy
);

  if (PULSE_CYC < `HRS_SRST_MIN_CYC || PULSE_CYC > 15) begin : g_bad_len
    $error("hrs_srst_pulse: pulse length out of range");
  end

  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic       srst_b_r;
  logic       srst_b_nxt;

  always_comb begin
    cnt_nxt    = cnt_r;
    srst_b_nxt = srst_b_r;
    if (!srst_b_r) begin
      if (cnt_r == 4'(PULSE_CYC - 1)) begin
        srst_b_nxt = 1'b1;
        cnt_nxt    = 4'h0;
      end else begin
        cnt_nxt = cnt_r + 4'h1;
      end
    end else if (i_enable && i_req) begin
      srst_b_nxt = 1'b0;
      cnt_nxt    = 4'h0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cnt_r    <= 4'h0;
      srst_b_r <= 1'b1;
    end else begin
      cnt_r    <= cnt_nxt;
      srst_b_r <= srst_b_nxt;
    end
  end

  assign o_srst_b = srst_b_r;
  assign o_busy   = !srst_b_r;

endmodule : hrs_srst_pulse
